// [bdr_core.sv]
// Background debug register set: status, instruction decode, shifter,
// address holder and condition-code save, with serial-idle watchdog.
// Assumes accesses arrive synchronous to i_core_clk from the debug engine.
//
// Function
// RL1: Permit bit gates entry into active mode
// RL2: Status resets zero; special modes set active
// RL3: Active flag maps debug resources in
// RL4: Active flag write lands four cycles later
// RL5: Host must not clear active via next-write
// RL6: Tag bit set by command, cleared on entry
// RL7: Tagging halts serial commands after sixteen cycles
// RL8: Shift-valid shows completed shift
// RL9: Trace flag set by single-step command
// RL10: Clock-select picks bus or alternate clock
// RL11: Host times clock switch at old rate
// RL12: Slow alternate clock forces alternate selection
// RL13: Idle 512 debug clocks clears instruction
// RL14: Hardware command bit decode
// RL15: Background bit only for background command
// RL16: Map bit selects debug or user map
// RL17: Step/tag/resume field decode
// RL18: Register-select field decode
// RL19: Next-word access pre-increments index by two
// RL20: Sixteen-bit shifter, read/write, scratch use
// RL21: Address holder written only by hardware
// RL22: Condition-code save register read/write
// RL23: Status write permissions per command type
// RL24: Registers reached through serial read/write
`timescale 1ns/1ps
module bdr_core
	import bdr_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Mode straps
	input wire logic i_special_mode,
	// Register access from the serial engine
	input wire bdr_acc_t i_acc,
	// Serial engine events
	input wire logic i_enter_background_request_entry,
	input wire logic i_shift_done,
	input wire logic i_shift_start,
	input wire logic i_shift_load,
	input wire logic [15:0] i_shift_data,
	input wire logic i_addr_load,
	input wire logic [15:0] i_addr_data,
	input wire logic i_host_fall,
	input wire logic i_dbg_tick,
	input wire logic i_cc_load,
	input wire logic [7:0] i_cc_data,
	input wire logic i_alt_slower,
	// Outputs
	output logic [7:0] o_rdata,
	output logic o_map_active,
	output logic o_permit,
	output logic o_serial_enable,
	output logic o_use_alt_clock,
	output bdr_cmd_t o_cmd,
	output logic [15:0] o_next_step,
	output logic [15:0] o_shift
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] instr_reg;
	logic [7:0] status_reg;
	logic [15:0] shift_reg;
	logic [15:0] addr_reg;
	logic [7:0] ccsave_reg;
	logic [9:0] idle_reg;
	logic [4:0] tag_cnt_reg;
	logic tag_armed_reg;
	logic serial_en_reg;
	logic rst_seen_reg;
	logic act_apply;
	logic act_value;
	logic wr_status;
	logic tag_set;
	logic tag_start;

	function automatic bdr_regsel_t dec_regsel(input logic [2:0] f);
		case (f) // RL18
			RSEL_NEXT: dec_regsel = BDR_REG_NEXT;
			RSEL_PC: dec_regsel = BDR_REG_PC;
			RSEL_D: dec_regsel = BDR_REG_D;
			RSEL_X: dec_regsel = BDR_REG_X;
			RSEL_Y: dec_regsel = BDR_REG_Y;
			RSEL_SP: dec_regsel = BDR_REG_SP;
			default: dec_regsel = BDR_REG_NONE;
		endcase
	endfunction

	function automatic logic hit(input bdr_acc_t a, input logic [15:0] ad);
		hit = a.addr == ad;
	endfunction

	assign wr_status = i_acc.wr && hit(i_acc, ADDR_STATUS);
	// Tag-and-resume command takes effect when its serial transfer finishes
	assign tag_set = !instr_reg[IN_HW] && instr_reg[IN_ENTER_BACKGROUND_REQUEST:IN_WORD] == TTG_TAG && !i_acc.rd
		&& i_shift_done; // RL6
	// Either way of writing the tag bit starts the hand-over count
	assign tag_start = (wr_status && i_acc.wdata[ST_TAG]) || tag_set; // RL7

	// ----------------------------------------
	// Active flag delayed write
	// ----------------------------------------
	// Writable only while a firmware command is in the instruction register
	bdr_delay #(
		.DELAY({2'b00, ACT_DELAY})
	) u_act_delay (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_start(wr_status && !instr_reg[IN_HW]), // RL4 RL23
		.i_value(i_acc.wdata[ST_ACTIVE]),
		.o_apply(act_apply),
		.o_value(act_value)
	);

	// ----------------------------------------
	// Status register
	// ----------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			status_reg <= REG_ZERO; // RL2
			rst_seen_reg <= 1'b1;
		end
		else if (i_ce)
		begin
			rst_seen_reg <= 1'b0;
			if (rst_seen_reg && i_special_mode)
				status_reg[ST_ACTIVE] <= 1'b1; // RL2
			if (wr_status)
			begin
				status_reg[ST_PERMIT] <= i_acc.wdata[ST_PERMIT]; // RL23
				status_reg[ST_TAG] <= i_acc.wdata[ST_TAG];
				status_reg[ST_SDV] <= i_acc.wdata[ST_SDV];
				status_reg[ST_TRACE] <= i_acc.wdata[ST_TRACE];
				if (instr_reg[IN_HW])
					status_reg[ST_CLKSEL] <= i_acc.wdata[ST_CLKSEL]; // RL23 RL10
			end
			if (i_shift_start)
				status_reg[ST_SDV] <= 1'b0; // RL8
			if (i_shift_done)
				status_reg[ST_SDV] <= 1'b1; // RL8
			if (act_apply)
				status_reg[ST_ACTIVE] <= act_value; // RL4
			if (tag_set)
				status_reg[ST_TAG] <= 1'b1; // RL6
			if (!instr_reg[IN_HW] && instr_reg[IN_ENTER_BACKGROUND_REQUEST:IN_WORD] == TTG_STEP && i_shift_done)
				status_reg[ST_TRACE] <= 1'b1; // RL9
			if (i_enter_background_request_entry && status_reg[ST_PERMIT])
			begin
				status_reg[ST_ACTIVE] <= 1'b1; // RL1 RL3
				status_reg[ST_TAG] <= 1'b0; // RL6
			end
		end
	end

	// ----------------------------------------
	// Tagging hand-over
	// ----------------------------------------
	// Serial processing stops only after the tag bit has settled
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			tag_cnt_reg <= 5'h00;
			tag_armed_reg <= 1'b0;
			serial_en_reg <= 1'b1;
		end
		else if (i_ce)
		begin
			if (tag_start)
			begin
				tag_cnt_reg <= TAG_DELAY - 5'h01; // RL7
				tag_armed_reg <= 1'b1;
			end
			else if (tag_armed_reg)
			begin
				tag_cnt_reg <= tag_cnt_reg - 5'h01;
				if (tag_cnt_reg == 5'h01)
				begin
					tag_armed_reg <= 1'b0;
					serial_en_reg <= 1'b0; // RL7
				end
			end
			if (!status_reg[ST_TAG])
				serial_en_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Instruction register and idle watchdog
	// ----------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			instr_reg <= REG_ZERO;
			idle_reg <= 10'h000;
		end
		else if (i_ce)
		begin
			if (i_host_fall)
				idle_reg <= 10'h000;
			else if (i_dbg_tick && idle_reg != IDLE_LIMIT)
				idle_reg <= idle_reg + 10'h001;
			if (i_acc.wr && hit(i_acc, ADDR_INSTR) && serial_en_reg)
				instr_reg <= i_acc.wdata; // RL24
			if (i_dbg_tick && !i_host_fall && idle_reg == IDLE_LIMIT - 10'h001)
				instr_reg <= REG_ZERO; // RL13
		end
	end

	// ----------------------------------------
	// Shifter, address holder, condition-code save
	// ----------------------------------------
	// Shifter and save registers have no reset: contents are undefined
	always_ff @(posedge i_core_clk)
	begin
		if (i_ce)
		begin
			if (i_shift_load)
				shift_reg <= i_shift_data; // RL20
			if (i_acc.wr && hit(i_acc, ADDR_SHIFT_HI))
				shift_reg[15:8] <= i_acc.wdata; // RL20
			if (i_acc.wr && hit(i_acc, ADDR_SHIFT_LO))
				shift_reg[7:0] <= i_acc.wdata; // RL20
			if (i_addr_load)
				addr_reg <= i_addr_data; // RL21
			if (i_cc_load)
				ccsave_reg <= i_cc_data; // RL22
			if (i_acc.wr && hit(i_acc, ADDR_CCSAVE))
				ccsave_reg <= i_acc.wdata; // RL22
		end
	end

	// ----------------------------------------
	// Read data and decoded outputs
	// ----------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			o_rdata <= REG_ZERO;
			o_map_active <= 1'b0;
			o_permit <= 1'b0;
			o_serial_enable <= 1'b1;
			o_use_alt_clock <= 1'b0;
			o_cmd <= '0;
			o_next_step <= NEXT_STEP;
			o_shift <= 16'h0000;
		end
		else if (i_ce)
		begin
			if (i_acc.rd)
			begin
				case (i_acc.addr) // RL24
					ADDR_INSTR: o_rdata <= instr_reg[IN_HW] ? (instr_reg & INSTR_HW_MASK) : instr_reg; // RL14
					ADDR_STATUS: o_rdata <= {status_reg[7:2], 2'b00};
					ADDR_SHIFT_HI: o_rdata <= shift_reg[15:8];
					ADDR_SHIFT_LO: o_rdata <= shift_reg[7:0];
					ADDR_ADDR_HI: o_rdata <= addr_reg[15:8]; // RL21
					ADDR_ADDR_LO: o_rdata <= addr_reg[7:0];
					ADDR_CCSAVE: o_rdata <= ccsave_reg;
					default: o_rdata <= REG_ZERO;
				endcase
			end
			o_map_active <= status_reg[ST_ACTIVE]; // RL3
			o_permit <= status_reg[ST_PERMIT]; // RL1
			o_serial_enable <= serial_en_reg; // RL7
			o_use_alt_clock <= status_reg[ST_CLKSEL] || i_alt_slower; // RL10 RL12
			o_cmd.hw <= instr_reg[IN_HW]; // RL14
			o_cmd.data <= instr_reg[IN_DATA];
			o_cmd.read <= instr_reg[IN_READ];
			o_cmd.enter_background_request <= instr_reg == INSTR_ENTER_BACKGROUND_REQUEST_CMD; // RL15
			o_cmd.word <= instr_reg[IN_HW] && instr_reg[IN_WORD];
			o_cmd.map <= instr_reg[IN_HW] && instr_reg[IN_MAP]; // RL16
			o_cmd.ttg <= instr_reg[IN_HW] ? TTG_NONE : instr_reg[IN_ENTER_BACKGROUND_REQUEST:IN_WORD]; // RL17
			o_cmd.regsel <= instr_reg[IN_HW] ? BDR_REG_NONE : dec_regsel(instr_reg[2:0]);
			o_next_step <= NEXT_STEP; // RL19
			o_shift <= shift_reg;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_idle_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL13
		i_ce && i_dbg_tick && !i_host_fall && idle_reg == IDLE_LIMIT - 10'h001
		|=> instr_reg == REG_ZERO) else $error("instruction not cleared on idle");
	a_entry_sets_active: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL3
		i_ce && i_enter_background_request_entry && status_reg[ST_PERMIT] |=> status_reg[ST_ACTIVE])
		else $error("active not set on entry");
	a_entry_clears_tag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL6
		i_ce && i_enter_background_request_entry && status_reg[ST_PERMIT] |=> !status_reg[ST_TAG])
		else $error("tag not cleared on entry");
	a_no_permit_entry: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL1
		i_ce && i_enter_background_request_entry && !status_reg[ST_PERMIT] && !status_reg[ST_ACTIVE]
		&& !act_apply && !rst_seen_reg |=> !status_reg[ST_ACTIVE])
		else $error("active entered without permit");
	a_act_delay: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL4
		i_ce && wr_status && !instr_reg[IN_HW] && !i_acc.wdata[ST_ACTIVE]
		##1 (i_ce && !wr_status && !i_enter_background_request_entry) [*4] |=> !status_reg[ST_ACTIVE])
		else $error("active write delay wrong");
	a_sdv_done: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL8
		i_ce && i_shift_done |=> status_reg[ST_SDV]) else $error("shift valid not set");
	a_alt_force: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL12
		i_ce && i_alt_slower |=> o_use_alt_clock) else $error("alternate clock not forced");
	a_enter_background_request_decode: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL15
		i_ce && $past(i_ce) && o_cmd.enter_background_request |-> $past(instr_reg) == INSTR_ENTER_BACKGROUND_REQUEST_CMD)
		else $error("background decode wrong");
	a_clksel_guard: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL23
		i_ce && wr_status && !instr_reg[IN_HW] |=> $stable(status_reg[ST_CLKSEL]))
		else $error("clock select written by firmware command");
	a_special_reset: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL2
		i_ce && rst_seen_reg && i_special_mode |=> status_reg[ST_ACTIVE])
		else $error("special mode did not set active");
	a_act_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL4
		i_ce && wr_status && !instr_reg[IN_HW] && !i_acc.wdata[ST_ACTIVE]
		&& status_reg[ST_ACTIVE] && !act_apply
		##1 (i_ce && !wr_status) [*4] |-> status_reg[ST_ACTIVE])
		else $error("active cleared before write delay");
	a_tag_cmd_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL6
		i_ce && tag_set && !i_enter_background_request_entry |=> status_reg[ST_TAG])
		else $error("tag not set by tag command");
	a_tag_serial_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL7
		i_ce && tag_armed_reg && !tag_start && tag_cnt_reg == 5'h01 && status_reg[ST_TAG]
		|=> !serial_en_reg) else $error("serial not stopped by tagging");
	a_instr_refused: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL7
		i_ce && !serial_en_reg && i_acc.wr && hit(i_acc, ADDR_INSTR) && !i_dbg_tick
		|=> $stable(instr_reg)) else $error("instruction written while tagging");
	a_trace_step: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL9
		i_ce && !instr_reg[IN_HW] && instr_reg[IN_ENTER_BACKGROUND_REQUEST:IN_WORD] == TTG_STEP && i_shift_done
		|=> status_reg[ST_TRACE]) else $error("trace not set by step command");
	a_hw_low_bits: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL14
		i_ce && i_acc.rd && hit(i_acc, ADDR_INSTR) && instr_reg[IN_HW]
		|=> (o_rdata & ~INSTR_HW_MASK) == REG_ZERO) else $error("hardware low bits not zero");
endmodule

// [bdr_pkg.sv]
// Package for the background debug register set: map, fields, timing.
// Assumes a single 50 MHz core clock domain.
package bdr_pkg;
	localparam logic [15:0] ADDR_INSTR = 16'hff00;
	localparam logic [15:0] ADDR_STATUS = 16'hff01;
	localparam logic [15:0] ADDR_SHIFT_HI = 16'hff02;
	localparam logic [15:0] ADDR_SHIFT_LO = 16'hff03;
	localparam logic [15:0] ADDR_ADDR_HI = 16'hff04;
	localparam logic [15:0] ADDR_ADDR_LO = 16'hff05;
	localparam logic [15:0] ADDR_CCSAVE = 16'hff06;
	localparam logic [7:0] REG_ZERO = 8'h00;
	localparam int ST_PERMIT = 7;
	localparam int ST_ACTIVE = 6;
	localparam int ST_TAG = 5;
	localparam int ST_SDV = 4;
	localparam int ST_TRACE = 3;
	localparam int ST_CLKSEL = 2;
	localparam int IN_HW = 7;
	localparam int IN_DATA = 6;
	localparam int IN_READ = 5;
	localparam int IN_ENTER_BACKGROUND_REQUEST = 4;
	localparam int IN_WORD = 3;
	localparam int IN_MAP = 2;
	localparam logic [7:0] INSTR_ENTER_BACKGROUND_REQUEST_CMD = 8'h90;
	localparam logic [7:0] INSTR_HW_MASK = 8'hfc;
	localparam logic [1:0] TTG_NONE = 2'h0;
	localparam logic [1:0] TTG_GO = 2'h1;
	localparam logic [1:0] TTG_STEP = 2'h2;
	localparam logic [1:0] TTG_TAG = 2'h3;
	localparam logic [2:0] RSEL_NEXT = 3'h2;
	localparam logic [2:0] RSEL_PC = 3'h3;
	localparam logic [2:0] RSEL_D = 3'h4;
	localparam logic [2:0] RSEL_X = 3'h5;
	localparam logic [2:0] RSEL_Y = 3'h6;
	localparam logic [2:0] RSEL_SP = 3'h7;
	localparam logic [15:0] NEXT_STEP = 16'h0002;
	localparam logic [2:0] ACT_DELAY = 3'h4;
	localparam logic [4:0] TAG_DELAY = 5'h10;
	localparam logic [9:0] IDLE_LIMIT = 10'h200;
	typedef enum logic [2:0] {
		BDR_REG_NONE,
		BDR_REG_NEXT,
		BDR_REG_PC,
		BDR_REG_D,
		BDR_REG_X,
		BDR_REG_Y,
		BDR_REG_SP
	} bdr_regsel_t;
	typedef struct packed {
		logic hw;
		logic data;
		logic read;
		logic enter_background_request;
		logic word;
		logic map;
		logic [1:0] ttg;
		bdr_regsel_t regsel;
	} bdr_cmd_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bdr_acc_t;
endpackage

// [bdr_delay.sv]
// Delayed-write pipe: applies a bit value a fixed count of cycles after capture.
// Assumes one clock; a new write restarts the count.
`timescale 1ns/1ps
module bdr_delay
	import bdr_pkg::*;
#(
	parameter logic [4:0] DELAY = 5'h04
)
(
	// Clock and control
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Request
	input wire logic i_start,
	input wire logic i_value,
	// Result
	output logic o_apply,
	output logic o_value
);
	logic [4:0] cnt_reg;
	logic busy_reg;
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			cnt_reg <= 5'h00;
			busy_reg <= 1'b0;
			o_apply <= 1'b0;
			o_value <= 1'b0;
		end
		else if (i_ce)
		begin
			o_apply <= 1'b0;
			if (i_start)
			begin
				cnt_reg <= DELAY - 5'h01;
				busy_reg <= 1'b1;
				o_value <= i_value;
			end
			else if (busy_reg)
			begin
				if (cnt_reg == 5'h01 || cnt_reg == 5'h00)
				begin
					busy_reg <= 1'b0;
					o_apply <= 1'b1;
				end
				cnt_reg <= cnt_reg - 5'h01;
			end
		end
	end
endmodule

// [bdr_host_model.sv]
// Host-side model: debug-clock ticks and host falling edges on the pin.
// Assumes the core clock; ticks run only while i_run is high.
`timescale 1ns/1ps
module bdr_host_model
	import bdr_pkg::*;
(
	// Clock and control
	input wire logic i_core_clk,
	input wire logic i_run,
	input wire logic i_slow,
	input wire logic i_fall,
	// Toward the debug unit, and a tick count for the bench
	output logic o_dbg_tick,
	output logic o_host_fall,
	output logic [15:0] o_ticks
);
	logic [1:0] div_reg;
	initial
	begin
		div_reg = 2'h0;
		o_dbg_tick = 1'b0;
		o_host_fall = 1'b0;
		o_ticks = 16'h0000;
	end
	// Rate is changed only between commands; no next-word store is ever issued
	always @(posedge i_core_clk)
	begin
		div_reg <= div_reg + 2'h1;
		o_host_fall <= i_fall;
		o_dbg_tick <= i_run && !i_fall && (!i_slow || div_reg == 2'h0);
		if (i_fall)
			o_ticks <= 16'h0000;
		else if (o_dbg_tick)
			o_ticks <= o_ticks + 16'h0001;
	end
endmodule

// [testbench.sv]
// Self-checking bench for the debug register set.
// Assumes the host model supplies debug ticks and host edges.
`timescale 1ns/1ps
module testbench;
	import bdr_pkg::*;
	localparam int E_ENT = 0, E_DONE = 1, E_START = 2, E_SLD = 3, E_ALD = 4, E_CC = 5;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sp = 1'b1;
	bdr_acc_t acc = '0;
	logic entry = 1'b0, sdone = 1'b0, sstart = 1'b0, sload = 1'b0, aload = 1'b0;
	logic ccload = 1'b0, slow = 1'b0, run = 1'b0, hslow = 1'b0, fall = 1'b0;
	logic [15:0] ld = 16'h0000;
	logic tick, hfall, map, permit, sen, alt;
	logic [15:0] ticks, nstep, shift;
	logic [7:0] rdata;
	bdr_cmd_t cmd;
	logic [7:0] hw_op [3] = '{8'heb, 8'h90, 8'he4};
	logic [15:0] hw_exp [3] = '{16'h003a, 16'h0024, 16'h0039};
	int miscompares = 0;
	int tests_run = 0;
	bdr_core uut (.i_core_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_special_mode(sp),
		.i_acc(acc), .i_enter_background_request_entry(entry), .i_shift_done(sdone), .i_shift_start(sstart),
		.i_shift_load(sload), .i_shift_data(ld), .i_addr_load(aload), .i_addr_data(ld),
		.i_host_fall(hfall), .i_dbg_tick(tick), .i_cc_load(ccload), .i_cc_data(ld[7:0]),
		.i_alt_slower(slow), .o_rdata(rdata), .o_map_active(map), .o_permit(permit),
		.o_serial_enable(sen), .o_use_alt_clock(alt), .o_cmd(cmd), .o_next_step(nstep),
		.o_shift(shift));
	bdr_host_model host (.i_core_clk(clk), .i_run(run), .i_slow(hslow), .i_fall(fall),
		.o_dbg_tick(tick), .o_host_fall(hfall), .o_ticks(ticks));
	initial
	begin
		forever #10 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic done(input int n);
		$display("test %0d finished", n);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc.addr = a;
		acc.wdata = d;
		acc.wr = 1'b1;
		cyc(1);
		acc.wr = 1'b0;
		cyc(1);
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		acc.addr = a;
		acc.rd = 1'b1;
		cyc(1);
		acc.rd = 1'b0;
		cyc(1);
		chk({8'h00, rdata}, {8'h00, e});
	endtask
	task automatic ev(input int k);
		{ccload, aload, sload, sstart, sdone, entry} = 6'(1 << k);
		cyc(1);
		{ccload, aload, sload, sstart, sdone, entry} = 6'h00;
		cyc(1);
	endtask
	task automatic host_fall();
		fall = 1'b1;
		cyc(1);
		fall = 1'b0;
		cyc(1);
	endtask
	// Waits are bounded so a stalled tick source cannot hang the run
	task automatic ticks_to(input logic [15:0] n);
		for (int i = 0; i < 4000 && ticks < n; i++)
			cyc(1);
		chk(16'(ticks >= n), 16'h0001);
	endtask
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		cyc(3);
		rst = 1'b0;
		cyc(3);
		chk(16'(map), 16'h0001);
		rchk(ADDR_STATUS, 8'h40);
		rchk(ADDR_INSTR, REG_ZERO);
		chk(nstep, NEXT_STEP);
		chk(16'(sen), 16'h0001);
		done(1);
		wr(ADDR_SHIFT_HI, 8'ha5);
		wr(ADDR_SHIFT_LO, 8'h3c);
		rchk(ADDR_SHIFT_HI, 8'ha5);
		chk(shift, 16'ha53c);
		ld = 16'hbeef;
		ev(E_SLD);
		ev(E_ALD);
		ev(E_CC);
		wr(ADDR_ADDR_HI, 8'h00);
		rchk(ADDR_SHIFT_LO, 8'hef);
		rchk(ADDR_ADDR_HI, 8'hbe);
		rchk(ADDR_ADDR_LO, 8'hef);
		rchk(ADDR_CCSAVE, 8'hef);
		wr(ADDR_CCSAVE, 8'h5a);
		rchk(ADDR_CCSAVE, 8'h5a);
		rchk(16'hff07, REG_ZERO);
		done(2);
		wr(ADDR_INSTR, 8'heb);
		rchk(ADDR_INSTR, 8'he8);
		foreach (hw_op[i])
		begin
			wr(ADDR_INSTR, hw_op[i]);
			cyc(1);
			chk(16'({cmd.hw, cmd.data, cmd.read, cmd.enter_background_request, cmd.word, cmd.map}), hw_exp[i]);
		end
		for (int t = 0; t < 4; t++)
		begin
			wr(ADDR_INSTR, 8'(t << 3));
			cyc(1);
			chk(16'(cmd.ttg), 16'(t));
		end
		for (int g = 0; g < 8; g++)
		begin
			wr(ADDR_INSTR, 8'(8'h40 + g));
			cyc(1);
			chk(16'(cmd.regsel), (g < 2) ? 16'h0000 : 16'(g - 1));
		end
		done(3);
		run = 1'b1;
		hslow = 1'b1;
		host_fall();
		ticks_to(16'h01f4);
		hslow = 1'b0;
		host_fall();
		ticks_to(16'h01f9);
		rchk(ADDR_INSTR, 8'h47);
		ticks_to(16'h0212);
		run = 1'b0;
		rchk(ADDR_INSTR, REG_ZERO);
		done(4);
		wr(ADDR_STATUS, 8'hc0);
		chk(16'(permit), 16'h0001);
		ev(E_START);
		rchk(ADDR_STATUS, 8'hc0);
		ev(E_DONE);
		rchk(ADDR_STATUS, 8'hd0);
		wr(ADDR_INSTR, 8'h10);
		ev(E_DONE);
		rchk(ADDR_STATUS, 8'hd8);
		wr(ADDR_INSTR, 8'h18);
		ev(E_DONE);
		rchk(ADDR_STATUS, 8'hf8);
		cyc(10);
		chk(16'(sen), 16'h0001);
		cyc(5);
		chk(16'(sen), 16'h0000);
		wr(ADDR_INSTR, 8'h47);
		rchk(ADDR_INSTR, 8'h18);
		ev(E_ENT);
		rchk(ADDR_STATUS, 8'hd8);
		chk(16'(sen), 16'h0001);
		done(5);
		wr(ADDR_INSTR, INSTR_ENTER_BACKGROUND_REQUEST_CMD);
		wr(ADDR_STATUS, 8'h84);
		rchk(ADDR_STATUS, 8'hc4);
		chk(16'(alt), 16'h0001);
		cyc(150);
		wr(ADDR_INSTR, REG_ZERO);
		wr(ADDR_STATUS, 8'h00);
		cyc(2);
		chk(16'(map), 16'h0001);
		cyc(4);
		chk(16'(map), 16'h0000);
		chk(16'(alt), 16'h0001);
		ev(E_ENT);
		chk(16'(map), 16'h0000);
		done(6);
		sp = 1'b0;
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		cyc(2);
		chk(16'({map, permit, alt}), 16'h0000);
		slow = 1'b1;
		cyc(2);
		chk(16'(alt), 16'h0001);
		wr(ADDR_STATUS, 8'h80);
		ev(E_ENT);
		chk(16'(map), 16'h0001);
		done(7);
		end_sim();
	end
	// Whole run is a few thousand cycles; this leaves a wide margin
	initial
	begin
		#400us;
		miscompares++;
		end_sim();
	end
endmodule
